// ---- hw/sdmr_fifo.sv ----
// Character queue, power-of-two depth, push allowed when full and popping
`timescale 1ns/1ps
module sdmr_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    sdmr_fifo_if.store q
);
    import sdmr_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } sdmr_fifo_s;
    sdmr_fifo_s s_r;
    sdmr_fifo_s s_nxt;
    logic       do_push;
    logic       do_pop;
    always_comb begin
        s_nxt   = s_r;
        do_pop  = q.pop && (s_r.cnt != '0);
        do_push = q.push && ((s_r.cnt != FULL_CNT) || do_pop);
        if (do_push) begin
            s_nxt.mem[s_r.wp] = q.push_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (do_pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        case ({do_push, do_pop})
            2'b10:   s_nxt.cnt = s_r.cnt + 1'b1;
            2'b01:   s_nxt.cnt = s_r.cnt - 1'b1;
            default: s_nxt.cnt = s_r.cnt;
        endcase
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q.head  = s_r.mem[s_r.rp];
    assign q.full  = (s_r.cnt == FULL_CNT);
    assign q.empty = (s_r.cnt == '0);
endmodule : sdmr_fifo

// ---- hw/sdmr_fifo_if.sv ----
// Carrier between the register block and its character queues
`timescale 1ns/1ps
interface sdmr_fifo_if #(parameter int W = 8);
    logic         push;
    logic [W-1:0] push_data;
    logic         pop;
    logic [W-1:0] head;
    logic         full;
    logic         empty;
    modport store (input push, push_data, pop, output head, full, empty);
    modport user  (output push, push_data, pop, input head, full, empty);
endinterface : sdmr_fifo_if

// ---- hw/sdmr_params.svh ----
// Register offsets, field positions and reset values of the block
`ifndef SDMR_PARAMS_SVH
`define SDMR_PARAMS_SVH
`define SDMR_OFS_MODEM   3'h0
`define SDMR_OFS_TXDATA  3'h1
`define SDMR_OFS_TXFLAGS 3'h2
`define SDMR_OFS_RXDATA  3'h3
`define SDMR_OFS_RXFLAGS 3'h4
`define SDMR_MODEM_PINS  5
`define SDMR_MODEM_LOOP  5
`define SDMR_MODEM_MASK  8'h3f
`define SDMR_MODEM_RST   8'h00
`define SDMR_TXF_NINTH   0
`define SDMR_TXF_PARITY  1
`define SDMR_TXF_MARKER  2
`define SDMR_TXF_MASK    8'h07
`define SDMR_TXF_RST     8'h00
`define SDMR_RXF_NINTH   5
`define SDMR_RXF_MASK    8'h7f
`define SDMR_LEN_NINE    4'h9
`define SDMR_BUS_W       14
`define SDMR_BUS_RST     14'h3fff
`endif

// ---- hw/sdmr_pkg.sv ----
// Types shared by the data and modem register block
package sdmr_pkg;
    typedef logic [7:0] sdmr_byte_t;
    typedef logic [1:0] sdmr_loop_t;
    typedef enum logic [1:0] {
        SDMR_MODE_PLAIN  = 2'b00,
        SDMR_MODE_MARKER = 2'b01,
        SDMR_MODE_SPAR   = 2'b10,
        SDMR_MODE_NINE   = 2'b11
    } sdmr_mode_e;
endpackage : sdmr_pkg

// ---- hw/sdmr_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module sdmr_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import sdmr_pkg::*;
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } sdmr_sync_s;
    sdmr_sync_s s_r;
    sdmr_sync_s s_nxt;
    always_comb begin
        s_nxt.meta = d;
        s_nxt.hold = s_r.meta;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= {RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end
    assign q = s_r.hold;
endmodule : sdmr_sync

// ---- hw/serial_data_modem_regs.sv ----
// Data and modem output registers of the serial controller
// What this block does
// - Each modem output pin set as a general output drives the complement of its written bit.
// - Modem bits only steer pins configured as general outputs.
// - One bit each for outputs 0, 1, 2, RTS and DTR.
// - Loopback bit enables loopback; variant comes from interface mode.
// - Data and flag registers accept host access at any time.
// - Writing transmit data pushes byte plus transmit flags to the queue.
// - Transmit data register is write-only; reads never return it.
// - Address marker mode sends the flagged marker bit.
// - Soft parity mode sends the flagged parity bit, none computed.
// - Nine-bit mode sends the flagged ninth bit as the top bit.
// - Receive data register shows the oldest held character.
// - Received character right-aligned, bits above length read zero.
// - First received character loads straight into receive data.
// - Reading receive data advances the queue, loading data and flags.
// - Receive flags load in the same step as receive data.
// - Received ninth bit holds the top bit, zero under nine bits.
`timescale 1ns/1ps
`include "sdmr_params.svh"
module serial_data_modem_regs #(
    parameter int TX_DEPTH = 4,
    parameter int RX_DEPTH = 4
) (
    input  wire  logic                 CORE_CLK,
    input  wire  logic                 RESETN,
    input  wire  logic                 CS_N,
    input  wire  logic                 RD_N,
    input  wire  logic                 WR_N,
    input  wire  logic [2:0]           ADDR,
    input  wire  sdmr_pkg::sdmr_byte_t DATA_IN,
    output sdmr_pkg::sdmr_byte_t       DATA_OUT,
    output logic                       DATA_OE,
    input  wire  logic [4:0]           PIN_GPO_SEL,
    input  wire  logic [4:0]           PIN_ALT,
    output logic [4:0]                 MODEM_PINS,
    input  wire  sdmr_pkg::sdmr_loop_t LOOP_MODE_SEL,
    output logic                       LOOPBACK_ON,
    output sdmr_pkg::sdmr_loop_t       LOOPBACK_TYPE,
    input  wire  logic [1:0]           CHAR_MODE,
    input  wire  logic                 TX_POP,
    output logic                       TX_AVAIL,
    output sdmr_pkg::sdmr_byte_t       TX_CHAR,
    output logic                       TX_EXTRA,
    output logic                       TX_EXTRA_EN,
    input  wire  logic                 RX_WRITE,
    input  wire  logic [8:0]           RX_CHAR,
    input  wire  sdmr_pkg::sdmr_byte_t RX_FLAGS,
    input  wire  logic [3:0]           RX_LEN,
    output logic                       RX_ROOM
);
    import sdmr_pkg::*;

    typedef struct packed {
        sdmr_byte_t modem;
        sdmr_byte_t txflag;
        sdmr_byte_t rxd;
        sdmr_byte_t receive_flags_register;
        logic       rx_full;
        logic [3:0] rx_len;
        sdmr_byte_t dout;
        logic       doe;
        logic [4:0] pins;
        logic       loop_on;
        sdmr_loop_t loop_sel;
        logic       wr_lo;
        logic       rd_lo;
        sdmr_byte_t wdata;
        logic [2:0] waddr;
        logic [2:0] raddr;
        sdmr_byte_t tx_char;
        logic       tx_extra;
        logic       tx_extra_en;
        logic       tx_avail;
        logic       rx_room;
    } sdmr_state_s;

    sdmr_state_s             s_r;
    sdmr_state_s             s_nxt;
    logic [`SDMR_BUS_W-1:0]  bus_s;
    logic                    cs_s;
    logic                    rd_s;
    logic                    wr_s;
    logic [2:0]              addr_s;
    sdmr_byte_t              din_s;
    logic                    wr_act;
    logic                    rd_act;
    logic                    wr_end;
    logic                    rd_start;
    logic                    rd_end;
    logic                    rx_adv;
    logic                    rx_need;
    logic                    rx_load;
    logic [8:0]              ld_char;
    sdmr_byte_t              ld_flags;
    sdmr_mode_e              mode;

    sdmr_fifo_if #(.W(11)) txif ();
    sdmr_fifo_if #(.W(17)) rxif ();

    // Keep only bits inside the character length
    function automatic sdmr_byte_t fit_char(logic [8:0] c, logic [3:0] len);
        sdmr_byte_t f;
        f = '0;
        for (int i = 0; i < 8; i++) begin
            f[i] = (4'(i) < len) ? c[i] : 1'b0;
        end
        return f;
    endfunction : fit_char

    function automatic logic ninth_of(logic [8:0] c, logic [3:0] len);
        return (len == `SDMR_LEN_NINE) ? c[8] : 1'b0;
    endfunction : ninth_of

    // Bus pins come from outside the clock domain
    sdmr_sync #(
        .W       (`SDMR_BUS_W),
        .RST_VAL (`SDMR_BUS_RST)
    ) u_bus_sync (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .d     ({CS_N, RD_N, WR_N, ADDR, DATA_IN}),
        .q     (bus_s)
    );

    sdmr_fifo #(.W(11), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .q     (txif.store)
    );

    sdmr_fifo #(.W(17), .DEPTH(RX_DEPTH)) u_rx_fifo (
        .clk   (CORE_CLK),
        .rst_n (RESETN),
        .q     (rxif.store)
    );

    assign cs_s   = bus_s[13];
    assign rd_s   = bus_s[12];
    assign wr_s   = bus_s[11];
    assign addr_s = bus_s[10:8];
    assign din_s  = bus_s[7:0];

    always_comb begin
        s_nxt    = s_r;
        mode     = sdmr_mode_e'(CHAR_MODE);
        wr_act   = !cs_s && !wr_s;
        rd_act   = !cs_s && !rd_s;
        wr_end   = s_r.wr_lo && !wr_act;
        rd_start = rd_act && !s_r.rd_lo;
        rd_end   = s_r.rd_lo && !rd_act;
        s_nxt.wr_lo = wr_act;
        s_nxt.rd_lo = rd_act;
        s_nxt.doe   = rd_act;

        // Last data seen while the strobe was low is committed at its end
        if (wr_act) begin
            s_nxt.wdata = din_s;
            s_nxt.waddr = addr_s;
        end

        if (rd_start) begin
            s_nxt.raddr = addr_s;
            case (addr_s)
                `SDMR_OFS_MODEM:   s_nxt.dout = s_r.modem;
                `SDMR_OFS_TXFLAGS: s_nxt.dout = s_r.txflag;
                `SDMR_OFS_RXDATA:  s_nxt.dout = s_r.rxd;
                `SDMR_OFS_RXFLAGS: s_nxt.dout = s_r.receive_flags_register;
                default:           s_nxt.dout = 8'h00;
            endcase
        end

        if (wr_end && (s_r.waddr == `SDMR_OFS_MODEM)) begin
            s_nxt.modem = s_r.wdata & `SDMR_MODEM_MASK;
        end
        if (wr_end && (s_r.waddr == `SDMR_OFS_TXFLAGS)) begin
            s_nxt.txflag = s_r.wdata & `SDMR_TXF_MASK;
        end

        for (int i = 0; i < `SDMR_MODEM_PINS; i++) begin
            s_nxt.pins[i] = PIN_GPO_SEL[i] ? !s_r.modem[i] : PIN_ALT[i];
        end

        s_nxt.loop_on  = s_r.modem[`SDMR_MODEM_LOOP];
        s_nxt.loop_sel = LOOP_MODE_SEL;

        txif.push      = wr_end && (s_r.waddr == `SDMR_OFS_TXDATA);
        txif.push_data = {s_r.txflag[2:0], s_r.wdata};
        txif.pop       = TX_POP && s_r.tx_avail;

        // Avail drops one cycle after each pop so no entry is taken twice
        s_nxt.tx_avail = !txif.empty && !txif.pop;
        s_nxt.tx_char  = txif.head[7:0];
        unique case (mode)
            SDMR_MODE_PLAIN: begin
                s_nxt.tx_extra    = 1'b0;
                s_nxt.tx_extra_en = 1'b0;
            end
            SDMR_MODE_MARKER: begin
                s_nxt.tx_extra    = txif.head[8 + `SDMR_TXF_MARKER];
                s_nxt.tx_extra_en = 1'b1;
            end
            SDMR_MODE_SPAR: begin
                s_nxt.tx_extra    = txif.head[8 + `SDMR_TXF_PARITY];
                s_nxt.tx_extra_en = 1'b1;
            end
            SDMR_MODE_NINE: begin
                s_nxt.tx_extra    = txif.head[8 + `SDMR_TXF_NINTH];
                s_nxt.tx_extra_en = 1'b1;
            end
        endcase

        rx_adv         = rd_end && (s_r.raddr == `SDMR_OFS_RXDATA);
        rx_need        = !s_r.rx_full || rx_adv;
        rx_load        = 1'b0;
        ld_char        = RX_CHAR;
        ld_flags       = RX_FLAGS;
        rxif.pop       = 1'b0;
        rxif.push      = 1'b0;
        rxif.push_data = {RX_FLAGS & `SDMR_RXF_MASK, RX_CHAR};
        if (rx_need) begin
            if (!rxif.empty) begin
                rx_load   = 1'b1;
                ld_char   = rxif.head[8:0];
                ld_flags  = rxif.head[16:9];
                rxif.pop  = 1'b1;
                rxif.push = RX_WRITE;
            end else if (RX_WRITE) begin
                rx_load = 1'b1;
            end else begin
                s_nxt.rx_full = 1'b0;
            end
        end else begin
            rxif.push = RX_WRITE && !rxif.full;
        end
        if (rx_load) begin
            s_nxt.rxd     = fit_char(ld_char, RX_LEN);
            s_nxt.receive_flags_register     = ld_flags & `SDMR_RXF_MASK;
            s_nxt.receive_flags_register[`SDMR_RXF_NINTH] = ninth_of(ld_char, RX_LEN);
            s_nxt.rx_len  = RX_LEN;
            s_nxt.rx_full = 1'b1;
        end
        s_nxt.rx_room = !rxif.full || rxif.pop;
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_r        <= '0;
            s_r.modem  <= `SDMR_MODEM_RST;
            s_r.txflag <= `SDMR_TXF_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign DATA_OUT      = s_r.dout;
    assign DATA_OE       = s_r.doe;
    assign MODEM_PINS    = s_r.pins;
    assign LOOPBACK_ON   = s_r.loop_on;
    assign LOOPBACK_TYPE = s_r.loop_sel;
    assign TX_AVAIL      = s_r.tx_avail;
    assign TX_CHAR       = s_r.tx_char;
    assign TX_EXTRA      = s_r.tx_extra;
    assign TX_EXTRA_EN   = s_r.tx_extra_en;
    assign RX_ROOM       = s_r.rx_room;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    AST_PIN_INVERT: assert property (
        PIN_GPO_SEL[3] |=> MODEM_PINS[3] == !$past(s_r.modem[3]))
        else $error("general output pin not complement of its bit");
    AST_PIN_ALT: assert property (
        !PIN_GPO_SEL[1] |=> MODEM_PINS[1] == $past(PIN_ALT[1]))
        else $error("alternate pin function disturbed");
    AST_PIN_OWN: assert property (
        wr_end && (s_r.waddr == `SDMR_OFS_MODEM) && PIN_GPO_SEL[4]
        ##1 PIN_GPO_SEL[4]
        |=> MODEM_PINS[4] == !$past(s_r.wdata[4], 2))
        else $error("dtr pin not steered by its own bit");
    AST_LOOP_ON: assert property (
        wr_end && (s_r.waddr == `SDMR_OFS_MODEM)
        |-> ##2 LOOPBACK_ON == $past(s_r.wdata[`SDMR_MODEM_LOOP], 2))
        else $error("loopback does not follow control bit");
    AST_TX_PUSH: assert property (
        wr_end && (s_r.waddr == `SDMR_OFS_TXDATA) && txif.empty
        |-> ##2 TX_AVAIL && (TX_CHAR == $past(s_r.wdata, 2)))
        else $error("written byte not offered to transmitter");
    AST_TX_WO: assert property (
        rd_start && (addr_s == `SDMR_OFS_TXDATA) |=> DATA_OUT == 8'h00)
        else $error("transmit data register returned a value");
    AST_TX_MARK: assert property (
        (CHAR_MODE == SDMR_MODE_MARKER) |=> TX_EXTRA_EN
        && (TX_EXTRA == $past(txif.head[8 + `SDMR_TXF_MARKER])))
        else $error("address marker bit not taken from flags");
    AST_TX_SPAR: assert property (
        (CHAR_MODE == SDMR_MODE_SPAR) |=> TX_EXTRA_EN
        && (TX_EXTRA == $past(txif.head[8 + `SDMR_TXF_PARITY])))
        else $error("soft parity bit not taken from flags");
    AST_TX_NINE: assert property (
        (CHAR_MODE == SDMR_MODE_NINE)
        |=> TX_EXTRA == $past(txif.head[8 + `SDMR_TXF_NINTH]))
        else $error("ninth data bit not taken from flags");
    AST_RX_ALIGN: assert property (
        rx_load |=> (s_r.rxd >> $past(RX_LEN)) == 8'h00)
        else $error("receive data has bits above length");
    AST_RX_FIRST: assert property (
        !s_r.rx_full && rxif.empty && RX_WRITE
        |=> s_r.rx_full && (s_r.rxd == fit_char($past(RX_CHAR),
                                                $past(RX_LEN))))
        else $error("first character not loaded directly");
    AST_RX_ADV: assert property (
        rx_adv && !rxif.empty
        |=> s_r.rxd == fit_char($past(rxif.head[8:0]), $past(RX_LEN)))
        else $error("read did not load next character");
    AST_RX_FLAGS: assert property (
        rx_adv && !rxif.empty && (RX_LEN != `SDMR_LEN_NINE)
        |=> s_r.receive_flags_register == ($past(rxif.head[16:9]) & `SDMR_RXF_MASK
                        & ~(8'h01 << `SDMR_RXF_NINTH)))
        else $error("receive flags not loaded with character");
    AST_RX_NINTH: assert property (
        s_r.rx_full && (s_r.rx_len != `SDMR_LEN_NINE)
        |-> !s_r.receive_flags_register[`SDMR_RXF_NINTH])
        else $error("ninth bit set for short character");

    COV_TX_PUSH: cover property (
        wr_end && (s_r.waddr == `SDMR_OFS_TXDATA) ##2 TX_AVAIL);
    COV_RX_FIRST: cover property (
        !s_r.rx_full && RX_WRITE ##1 s_r.rx_full);
    COV_RX_ADV: cover property (rx_adv && !rxif.empty);
    COV_LOOP: cover property (!LOOPBACK_ON ##1 LOOPBACK_ON);
endmodule : serial_data_modem_regs

// ---- tb/sdmr_line_model.sv ----
// Behavioural transmit and receive machines at the serial side
`timescale 1ns/1ps
module sdmr_line_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pop_en,
    input  wire logic       tx_avail,
    input  wire logic [7:0] tx_char,
    input  wire logic       tx_extra,
    input  wire logic       tx_extra_en,
    output logic            tx_pop,
    output logic [9:0]      got,
    output int              got_n,
    input  wire logic       send,
    input  wire logic [8:0] ch,
    input  wire logic [7:0] fl,
    output logic            rx_write,
    output logic [8:0]      rx_char,
    output logic [7:0]      rx_flags
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pop   <= 1'b0;
            got      <= 10'h000;
            got_n    <= 0;
            rx_write <= 1'b0;
            rx_char  <= 9'h000;
            rx_flags <= 8'h00;
        end else begin
            // Pop only a valid head, one cycle at a time
            tx_pop <= pop_en && tx_avail && !tx_pop;
            if (tx_pop && tx_avail) begin
                got   <= {tx_extra_en, tx_extra, tx_char};
                got_n <= got_n + 1;
            end
            rx_write <= send;
            // Lines toggle when nothing is delivered
            rx_char  <= send ? ch : ~rx_char;
            rx_flags <= send ? fl : ~rx_flags;
        end
    end
endmodule : sdmr_line_model

// ---- tb/testbench.sv ----
// Register level test of the data and modem register block
`timescale 1ns/1ps
`include "sdmr_params.svh"
module testbench;
    import sdmr_pkg::*;
    logic       clk = 0, rst_n = 0, cs_n = 1, rd_n = 1, wr_n = 1;
    logic [2:0] addr = 3'h0;
    sdmr_byte_t din = 8'h00, dout, q, receive_flags_register;
    logic [4:0] sel = 5'h1f, alt = 5'h00, pins;
    sdmr_loop_t lsel = 2'b10, ltype;
    logic [1:0] mode = 2'h0;
    logic [3:0] rlen = 4'h9;
    logic       oe, lon, pop, avail, ext, exten, rxw, room, pen = 0, snd = 0;
    sdmr_byte_t txc;
    logic [8:0] rxc, sch = 9'h000;
    logic [7:0] sfl = 8'h00;
    logic [9:0] got, ex;
    logic [8:0] rx_in [5] = '{9'h1ff, 9'h012, 9'h134, 9'h056, 9'h078};
    sdmr_byte_t rx_exp [5] = '{8'h7f, 8'h12, 8'h34, 8'h56, 8'h78};
    int         got_n, n0, fail_count = 0, compares = 0;
    logic [2:0] tf [4] = '{3'b000, 3'b011, 3'b010, 3'b110};
    logic       tx_exp [4] = '{1'b0, 1'b0, 1'b1, 1'b0};

    always #12.5 clk = ~clk;

    serial_data_modem_regs u_serial_data_modem_regs (
        .CORE_CLK(clk), .RESETN(rst_n), .CS_N(cs_n), .RD_N(rd_n),
        .WR_N(wr_n), .ADDR(addr), .DATA_IN(din), .DATA_OUT(dout),
        .DATA_OE(oe), .PIN_GPO_SEL(sel), .PIN_ALT(alt),
        .MODEM_PINS(pins), .LOOP_MODE_SEL(lsel), .LOOPBACK_ON(lon),
        .LOOPBACK_TYPE(ltype), .CHAR_MODE(mode), .TX_POP(pop),
        .TX_AVAIL(avail), .TX_CHAR(txc), .TX_EXTRA(ext),
        .TX_EXTRA_EN(exten), .RX_WRITE(rxw), .RX_CHAR(rxc),
        .RX_FLAGS(receive_flags_register), .RX_LEN(rlen), .RX_ROOM(room));

    sdmr_line_model u_sdmr_line_model (
        .clk(clk), .rst_n(rst_n), .pop_en(pen), .tx_avail(avail),
        .tx_char(txc), .tx_extra(ext), .tx_extra_en(exten),
        .tx_pop(pop), .got(got), .got_n(got_n), .send(snd), .ch(sch),
        .fl(sfl), .rx_write(rxw), .rx_char(rxc), .rx_flags(receive_flags_register));

    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_byte

    task automatic chk_line(input logic [9:0] g, input logic [9:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_line

    // Strobes held low four cycles, released five
    task automatic bus(input logic wr, input logic [2:0] a,
                       input sdmr_byte_t d, output sdmr_byte_t r);
        @(posedge clk);
        cs_n <= 1'b0;
        addr <= a;
        din  <= d;
        if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (4) @(posedge clk);
        r = dout;
        chk_byte({7'h00, oe}, {7'h00, !wr});
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk_byte({7'h00, oe}, 8'h00);
    endtask : bus

    task automatic wr(input logic [2:0] a, input sdmr_byte_t d);
        sdmr_byte_t r;
        bus(1'b1, a, d, r);
    endtask : wr

    task automatic send(input logic [8:0] c, input logic [7:0] f);
        @(posedge clk);
        snd <= 1'b1;
        sch <= c;
        sfl <= f;
        @(posedge clk);
        snd <= 1'b0;
        @(posedge clk);
    endtask : send

    task automatic tally_and_finish;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        // Walk each modem bit through its own pin
        for (int i = 0; i < 5; i++) begin
            wr(`SDMR_OFS_MODEM, 8'h01 << i);
            chk_line({5'h00, pins}, {5'h00, ~(5'h01 << i)});
            bus(1'b0, `SDMR_OFS_MODEM, 8'h00, q);
            chk_byte(q, 8'h01 << i);
        end
        sel <= 5'b00101;
        alt <= 5'b11010;
        wr(`SDMR_OFS_MODEM, 8'h35);
        chk_line({5'h00, pins}, 10'h01a);
        chk_line({8'h00, lon, ltype[0]}, 10'h002);
        chk_line({8'h00, ltype}, 10'h002);
        lsel <= 2'b01;
        repeat (2) @(posedge clk);
        chk_line({8'h00, ltype}, 10'h001);
        sel <= 5'h1f;
        wr(3'h7, 8'hff);
        bus(1'b0, 3'h7, 8'h00, q);
        chk_byte(q, 8'h00);
        bus(1'b0, `SDMR_OFS_MODEM, 8'h00, q);
        chk_byte(q, 8'h35);
        // Every character mode through the queue
        pen <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            mode <= i[1:0];
            n0 = got_n;
            ex = {i != 0, tx_exp[i], 8'h30 + i[7:0]};
            wr(`SDMR_OFS_TXFLAGS, {5'h00, tf[i]});
            wr(`SDMR_OFS_TXDATA, 8'h30 + i[7:0]);
            repeat (6) @(posedge clk);
            chk_line(got, ex);
            chk_byte(8'(got_n - n0), 8'h01);
            bus(1'b0, `SDMR_OFS_TXFLAGS, 8'h00, q);
            chk_byte(q, {5'h00, tf[i]});
            bus(1'b0, `SDMR_OFS_TXDATA, 8'h00, q);
            chk_byte({7'h00, q === 8'h30 + i[7:0]}, 8'h00);
        end
        // Fill past depth with the transmitter stalled
        pen <= 1'b0;
        n0 = got_n;
        for (int i = 0; i < 5; i++) wr(`SDMR_OFS_TXDATA, 8'h80 + i[7:0]);
        pen <= 1'b1;
        repeat (20) @(posedge clk);
        chk_byte(8'(got_n - n0), 8'h04);
        chk_byte(got[7:0], 8'h83);
        // First character readable at once
        send(9'h1a5, 8'hc1);
        bus(1'b0, `SDMR_OFS_RXFLAGS, 8'h00, q);
        chk_byte(q, 8'h61);
        bus(1'b0, `SDMR_OFS_RXDATA, 8'h00, q);
        chk_byte(q, 8'ha5);
        // Holding register plus a full queue, then oldest first
        rlen <= 4'h7;
        for (int i = 0; i < 5; i++) send(rx_in[i], 8'h01 << i);
        repeat (2) @(posedge clk);
        chk_byte({7'h00, room}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, `SDMR_OFS_RXFLAGS, 8'h00, q);
            chk_byte(q, 8'h01 << i);
            bus(1'b0, `SDMR_OFS_RXDATA, 8'h00, q);
            chk_byte(q, rx_exp[i]);
        end
        chk_byte({7'h00, room}, 8'h01);
        tally_and_finish();
    end
endmodule : testbench
